// ===== logic/rasc_ctrl.sv
// Reset sequencing, address strap latch and speaker fault pin control
//
// Operation
// RL1: The controller holds the active-low power-down input low at least 100 us to reset.
// RL2: The control port becomes usable within 12 ms of release; no access may start before.
// RL3: At power-up the shared pin is an input and its strapped level is sampled.
// RL4: High strap gives address 1010101, low gives 1010100, with the R/W bit eighth.
// RL5: After power-up a control setting can turn the shared pin into a fault output.
// RL6: Out of reset with no audio, the speaker outputs switch at a 50/50 mute pattern.
// RL7: With the fault output on, overcurrent, overtemperature and undervoltage drive it.
// RL8: The control port stays usable even when the audio master clock is absent.
// RL9: The latched address holds until the next reset, even after the pin is repurposed.
`timescale 1ns/1ps
`include "rasc_consts.svh"

module rasc_ctrl #(
	parameter int START_CYC = `RASC_START_CYC
) (
	input wire logic clk_sys, // System clock, 20 MHz
	input wire logic rst, // Power-on reset, active high
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic power_down_input_n, // Active-low reset pin from controller
	input wire logic adr_fault_i, // Shared pin, input level
	output logic adr_fault_o, // Shared pin, output level
	output logic adr_fault_oe, // Shared pin, high while driven
	input wire logic fault_pin_en, // Control setting: pin is fault output
	input wire logic fault_oc, // Overcurrent fault
	input wire logic fault_ot, // Overtemperature fault
	input wire logic fault_uv, // Undervoltage fault
	input wire logic audio_active, // Audio playback commanded
	input wire logic mclk_valid, // Audio master clock present
	output logic [6:0] slave_addr, // Latched control-port address
	output logic ctrl_port_ready, // Control port usable
	output logic reset_held, // Device held in reset
	output logic [2:0] err_status, // Live fault flags: uv, ot, oc
	output logic mute_pwm, // 50/50 idle mute pattern
	output logic mute_active // Mute pattern in use
);

	// ****************************************
	// Reset qualification and sequencing
	// ****************************************

	rasc_pkg::rasc_state_t state_q;
	logic [12:0] low_cnt_q;
	logic [$clog2(START_CYC+1)-1:0] start_cnt_q;
	logic low_ok;
	logic pin_low;

	assign pin_low = !power_down_input_n;
	// RL1 width check
	assign low_ok = (low_cnt_q >= 13'(`RASC_RST_MIN_CYC));

	// Counts how long the pin has been low; saturates to avoid wrap
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			low_cnt_q <= '0;
		end else if (ce) begin
			if (!pin_low) begin
				low_cnt_q <= '0;
			end else if (!low_ok) begin
				low_cnt_q <= low_cnt_q + 13'h1;
			end
		end
	end

	// Short glitches never reset the device, only a full-width pulse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= rasc_pkg::RASC_HELD;
			start_cnt_q <= '0;
		end else if (ce) begin
			case (state_q)
				rasc_pkg::RASC_HELD: begin
					start_cnt_q <= '0;
					if (!pin_low) begin
						state_q <= rasc_pkg::RASC_STRAP;
					end
				end
				rasc_pkg::RASC_STRAP: begin
					state_q <= rasc_pkg::RASC_START;
				end
				// RL2 startup delay
				rasc_pkg::RASC_START: begin
					if (low_ok) begin
						state_q <= rasc_pkg::RASC_HELD;
					end else if (start_cnt_q == ($bits(start_cnt_q))'(START_CYC - 1)) begin
						state_q <= rasc_pkg::RASC_READY;
					end else begin
						start_cnt_q <= start_cnt_q + 1'b1;
					end
				end
				rasc_pkg::RASC_READY: begin
					if (low_ok) begin
						state_q <= rasc_pkg::RASC_HELD;
					end
				end
				default: begin
					state_q <= rasc_pkg::RASC_HELD;
				end
			endcase
		end
	end

	assign reset_held = (state_q == rasc_pkg::RASC_HELD);
	// RL8 no audio clock needed
	assign ctrl_port_ready = (state_q == rasc_pkg::RASC_READY);

	// ****************************************
	// Address strap
	// ****************************************

	// RL3 sample strap
	// RL9 hold address
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			slave_addr <= `RASC_ADDR_LO;
		end else if (ce && state_q == rasc_pkg::RASC_STRAP) begin
			// RL4 address select
			slave_addr <= adr_fault_i ? `RASC_ADDR_HI : `RASC_ADDR_LO;
		end
	end

	// ****************************************
	// Fault pin
	// ****************************************

	logic pin_is_fault;
	assign pin_is_fault = ctrl_port_ready && fault_pin_en;

	// RL7 fault reporting
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			err_status <= 3'h0;
			adr_fault_o <= 1'b0;
		end else if (ce) begin
			err_status <= {fault_uv, fault_ot, fault_oc};
			adr_fault_o <= pin_is_fault && (fault_uv || fault_ot || fault_oc);
		end
	end

	// RL5 pin repurpose
	assign adr_fault_oe = pin_is_fault;

	// ****************************************
	// Idle mute pattern
	// ****************************************

	logic [7:0] mute_cnt_q;
	assign mute_active = !reset_held && !(audio_active && mclk_valid);

	// RL6 idle mute
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mute_cnt_q <= 8'h0;
			mute_pwm <= 1'b0;
		end else if (ce) begin
			if (!mute_active) begin
				mute_cnt_q <= 8'h0;
				mute_pwm <= 1'b0;
			end else if (mute_cnt_q == `RASC_MUTE_HALF) begin
				mute_cnt_q <= 8'h0;
				mute_pwm <= !mute_pwm;
			end else begin
				mute_cnt_q <= mute_cnt_q + 8'h1;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************

	a_addr_stable: assert property (@(posedge clk_sys) disable iff (rst) // RL9
		(state_q == rasc_pkg::RASC_READY && $past(state_q) == rasc_pkg::RASC_READY)
		|-> $stable(slave_addr)) else $error("address changed while ready");

	a_addr_map: assert property (@(posedge clk_sys) disable iff (rst) // RL4
		(ce && state_q == rasc_pkg::RASC_STRAP)
		|=> slave_addr == ($past(adr_fault_i) ? `RASC_ADDR_HI : `RASC_ADDR_LO))
		else $error("bad address");

	a_pin_input: assert property (@(posedge clk_sys) disable iff (rst) // RL3
		!ctrl_port_ready |-> !adr_fault_oe) else $error("pin driven during power-up");

	a_fault_out: assert property (@(posedge clk_sys) disable iff (rst) // RL7
		(ce && pin_is_fault && fault_ot) |=> adr_fault_o) else $error("fault not shown");

	a_ready_late: assert property (@(posedge clk_sys) disable iff (rst) // RL2
		$rose(ctrl_port_ready) |-> $past(state_q) == rasc_pkg::RASC_START)
		else $error("ready without startup");

	a_mute_run: assert property (@(posedge clk_sys) disable iff (rst) // RL6
		(ce && mute_active && mute_cnt_q == `RASC_MUTE_HALF) |=> mute_pwm != $past(mute_pwm))
		else $error("mute pattern stalled");

	a_short_pulse: assert property (@(posedge clk_sys) disable iff (rst) // RL1
		(ctrl_port_ready && !low_ok) |=> (ctrl_port_ready || !ce))
		else $error("short pulse reset device");

	a_oe_follows: assert property (@(posedge clk_sys) disable iff (rst) // RL5
		(ctrl_port_ready && fault_pin_en) |-> adr_fault_oe) else $error("pin not repurposed");

	a_strap_next: assert property (@(posedge clk_sys) disable iff (rst) // RL3
		(ce && reset_held && power_down_input_n) |=> (state_q == rasc_pkg::RASC_STRAP))
		else $error("strap not sampled after release");

	a_low_reset: assert property (@(posedge clk_sys) disable iff (rst) // RL1
		(ce && low_ok && !reset_held) |=> reset_held) else $error("full pulse ignored");

	a_ready_count: assert property (@(posedge clk_sys) disable iff (rst) // RL2
		$rose(ctrl_port_ready) |-> (start_cnt_q == ($bits(start_cnt_q))'(START_CYC - 1)))
		else $error("startup count cut short");

	a_err_live: assert property (@(posedge clk_sys) disable iff (rst) // RL7
		ce |=> (err_status == {$past(fault_uv), $past(fault_ot), $past(fault_oc)}))
		else $error("fault status lost");

	a_fault_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RL5
		(ce && !pin_is_fault) |=> !adr_fault_o) else $error("fault driven while input");

	a_mute_off: assert property (@(posedge clk_sys) disable iff (rst) // RL6
		(ce && !mute_active) |=> !mute_pwm) else $error("mute pattern left running");

endmodule : rasc_ctrl

// ===== pkg/rasc_consts.svh
// Constants for the reset and address strap control block
`ifndef RASC_CONSTS_SVH
`define RASC_CONSTS_SVH
`define RASC_CLK_HZ 20000000
`define RASC_RST_MIN_NS 100000
`define RASC_RST_MIN_CYC ((`RASC_RST_MIN_NS * 20 + 999) / 1000)
`define RASC_START_MAX_MS 12
`define RASC_START_CYC (`RASC_START_MAX_MS * (`RASC_CLK_HZ / 1000))
`define RASC_ADDR_HI 7'h55
`define RASC_ADDR_LO 7'h54
`define RASC_MUTE_HALF 8'h19
`endif

// ===== pkg/rasc_pkg.sv
// Types for the reset and address strap control block
package rasc_pkg;
	typedef enum logic [1:0] {
		RASC_HELD,
		RASC_STRAP,
		RASC_START,
		RASC_READY
	} rasc_state_t;
endpackage : rasc_pkg

// ===== tb/rasc_host.sv
// System controller model: power-down pin and strap resistor
`timescale 1ns/1ps
module rasc_host (
	input wire logic clk_sys, // System clock
	output logic power_down_input_n, // Active-low reset pin
	output logic strap_lvl // Level of the strap resistor
);
	// Held low from power-up, so the device starts in reset
	initial begin
		power_down_input_n = 1'b0;
		strap_lvl = 1'b1;
	end
	task automatic pulse(input int n, input logic lvl);
		power_down_input_n = 1'b0;
		strap_lvl = lvl;
		repeat (n) @(negedge clk_sys);
		power_down_input_n = 1'b1;
	endtask : pulse
endmodule : rasc_host

// ===== tb/test_reset_addr_strap_control.sv
// Self-checking bench for the reset and strap control block
`timescale 1ns/1ps
module test_reset_addr_strap_control;
	localparam int SC = 20;
	logic clk_sys = 0, rst = 1, pin_n, strap, fen = 0, oc = 0, ot = 0, uv = 0;
	logic aud = 0, mclk = 1, fo, foe, rdy, held, mpwm, mact, lvl, ce = 1;
	logic [6:0] addr;
	logic [2:0] err, f;
	logic [7:0] n;
	logic [6:0] exp_q[$];
	int seed = 67604, error_cnt = 0, num_checks = 0, cyc = 0;
	// Wire level: pull resistor unless the block drives it
	wire pin = foe ? fo : strap;
	rasc_host u_host (.clk_sys(clk_sys), .power_down_input_n(pin_n), .strap_lvl(strap));
	rasc_ctrl #(.START_CYC(SC)) u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.power_down_input_n(pin_n), .adr_fault_i(pin), .adr_fault_o(fo),
		.adr_fault_oe(foe), .fault_pin_en(fen), .fault_oc(oc), .fault_ot(ot),
		.fault_uv(uv), .audio_active(aud), .mclk_valid(mclk), .slave_addr(addr),
		.ctrl_port_ready(rdy), .reset_held(held), .err_status(err), .mute_pwm(mpwm),
		.mute_active(mact));
	always #25 clk_sys = ~clk_sys;
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic results();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	// Hang guard, well beyond the two reset passes
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 12000) begin
			error_cnt++;
			results();
		end
	end
	// Oldest noted address compared when the port comes up
	always @(posedge rdy) begin
		#1;
		if (exp_q.size() > 0) check("addr", {1'b0, addr}, {1'b0, exp_q.pop_front()});
	end
	// ************************************
	// Main sequence
	// ************************************
	initial begin
		repeat (5) @(negedge clk_sys);
		rst = 0;
		repeat (2) begin
			lvl = 1'($random(seed));
			exp_q.push_back(lvl ? 7'h55 : 7'h54);
			u_host.pulse(2010, lvl);
			// Release edge not yet sampled, so the block is still held
			check("held", {7'h0, held}, 8'h01);
			check("oe0", {7'h0, foe}, 8'h00);
			repeat (SC + 3) @(negedge clk_sys);
			mclk = 0;
			@(negedge clk_sys);
			check("ready", {7'h0, rdy}, 8'h01);
			check("mute", {7'h0, mact}, 8'h01);
			n = 0;
			repeat (52) @(negedge clk_sys) n += mpwm;
			check("duty", n, 8'h1a);
			// Enable low must freeze status and pattern, longer than a half period
			n = {7'h0, mpwm};
			ce = 0;
			f = 3'($random(seed));
			{uv, ot, oc} = f;
			repeat (30) @(negedge clk_sys);
			check("freeze", {4'h0, err, mpwm}, n);
			ce = 1;
			fen = 1;
			@(negedge clk_sys);
			check("oe", {7'h0, foe}, 8'h01);
			check("fo", {7'h0, fo}, {7'h0, |f});
			check("err", {5'h0, err}, {5'h0, f});
			u_host.pulse(100, ~lvl);
			repeat (3) @(negedge clk_sys);
			check("rdy2", {7'h0, rdy}, 8'h01);
			check("addr2", {1'b0, addr}, lvl ? 8'h55 : 8'h54);
			{fen, uv, ot, oc, mclk, aud} = 6'h03;
			@(negedge clk_sys);
			check("mute2", {7'h0, mact}, 8'h00);
			aud = 0;
		end
		// Every noted address must have met a rising ready
		check("pending", 8'(exp_q.size()), 8'h00);
		results();
	end
endmodule : test_reset_addr_strap_control
